// ---- common/msc_pkg.sv ----
// Constants shared by the mode select and system control block.
// Assumes one 100 MHz clock and a small byte-wide register port.
package msc_pkg;
    // Register port geometry
    localparam int MSC_ADDR_W = 2;
    localparam int MSC_DATA_W = 8;
    // Number of bus areas reported by the bus controller
    localparam int MSC_AREA_N = 8;
    // Register offsets (indices on the register port)
    localparam logic [1:0] MSC_OFS_MODE_MON = 2'h0;
    localparam logic [1:0] MSC_OFS_SYS_CTRL = 2'h1;
    // Mode monitor layout: bit 7 reads one, bits 6..3 read zero
    localparam logic [7:0] MSC_MON_FIXED = 8'h80;
    localparam logic [2:0] MSC_STATUS_RESET = 3'h0;
    // System control field positions
    localparam int MSC_SC_RSVD_HI = 7;
    localparam int MSC_SC_IRQ_HI = 5;
    localparam int MSC_SC_IRQ_LO = 4;
    localparam int MSC_SC_NMI_EDGE = 3;
    localparam int MSC_SC_MANUAL_RESET_PIN_EN = 2;
    localparam int MSC_SC_RAM_EN = 0;
    // Writable bits of system control; bits 6 and 1 stay zero
    localparam logic [7:0] MSC_SC_WR_MASK = 8'hbd;
    // System control value after reset: only the RAM enable set
    localparam logic [7:0] MSC_SC_RESET = 8'h01;
    // Interrupt control mode encodings
    localparam logic [1:0] MSC_IRQ_MODE0 = 2'h0;
    localparam logic [1:0] MSC_IRQ_MODE2 = 2'h2;
    // Edge select value for falling edge
    localparam logic MSC_EDGE_FALL = 1'b0;
    // Mode pin patterns
    localparam logic [2:0] MSC_MODE4 = 3'h4;
    localparam logic [2:0] MSC_MODE5 = 3'h5;
    localparam logic [2:0] MSC_MODE6 = 3'h6;
    localparam logic [2:0] MSC_MODE7 = 3'h7;
endpackage : msc_pkg

// ---- hdl/msc_mode_decode.sv ----
// Decodes the three mode pins into ROM, bus and width strap values.
// Assumes the caller registers the outputs while reset is asserted.
`timescale 1ns/1ns
module msc_mode_decode
    import msc_pkg::*;
(
    input wire logic [2:0] mode_pins_i,
    output logic rom_en_o,
    output logic ext_mode_o,
    output logic init_16_o
);
    // Pure table lookup; patterns with the top pin low are not legal
    // straps and fall back to single-chip, the safest choice
    always_comb
    begin
        case (mode_pins_i)
            MSC_MODE4:
            begin
                rom_en_o = 1'b0;
                ext_mode_o = 1'b1;
                init_16_o = 1'b1;
            end
            MSC_MODE5:
            begin
                rom_en_o = 1'b0;
                ext_mode_o = 1'b1;
                init_16_o = 1'b0;
            end
            MSC_MODE6:
            begin
                rom_en_o = 1'b1;
                ext_mode_o = 1'b1;
                init_16_o = 1'b0;
            end
            default:
            begin
                // Single-chip: ROM on, no external space
                rom_en_o = 1'b1;
                ext_mode_o = 1'b0;
                init_16_o = 1'b0;
            end
        endcase
    end
endmodule : msc_mode_decode

// ---- hdl/msc_edge_det.sv ----
// Edge detector with selectable polarity, one-cycle registered pulse.
// Assumes the input is already synchronous to the clock.
`timescale 1ns/1ns
module msc_edge_det
    import msc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic sig_i,
    input wire logic rise_sel_i,
    output logic pulse_o
);
    typedef struct packed {
        logic armed;  // Set once a previous sample exists
        logic prev;   // Last sample of the input
        logic pulse;  // Registered request pulse
    } msc_edge_state_t;

    msc_edge_state_t state_ff;
    msc_edge_state_t nxt_state;

    // Compare with the last sample; the armed bit stops a false edge
    // right after reset when the previous sample is not yet known
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.armed = 1'b1;
        nxt_state.prev = sig_i;
        if (rise_sel_i == MSC_EDGE_FALL)
            nxt_state.pulse = state_ff.armed & state_ff.prev & ~sig_i;
        else
            nxt_state.pulse = state_ff.armed & ~state_ff.prev & sig_i;
    end

    // State register
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    assign pulse_o = state_ff.pulse;
endmodule : msc_edge_det

// ---- hdl/msc_top.sv ----
// Mode select and system control: strap decode, mode monitor and
// system control registers, manual reset gating and NMI edge request.
// Assumes synchronous pins, a 100 MHz clock and a byte register port.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ns
module msc_top
    import msc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [2:0] mode_pin_i,
    input wire logic manual_reset_pin_n_i,
    input wire logic nmi_pin_i,
    input wire logic [MSC_AREA_N-1:0] area_16bit_i,
    input wire logic area_cfg_wr_i,
    input wire logic [MSC_ADDR_W-1:0] addr_i,
    input wire logic [MSC_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [MSC_DATA_W-1:0] rdata_o,
    output logic rom_enable_o,
    output logic extended_mode_o,
    output logic init_bus_16bit_o,
    output logic bus_16bit_o,
    output logic [1:0] irq_ctrl_mode_o,
    output logic nmi_req_o,
    output logic manual_reset_o,
    output logic onchip_ram_enable_o,
    output logic ram_region_external_o
);
    typedef struct packed {
        logic [2:0] mode_status;  // Pin levels caught at last monitor read
        logic [7:0] sys_ctrl;     // System control storage
        logic rom_en;             // Strap: on-chip ROM usable
        logic ext_mode;           // Strap: external bus present
        logic init_16;            // Strap: initial bus width is 16
        logic cfg_seen;           // Bus controller has written area widths
        logic bus_16;             // Current external bus width is 16
        logic manual_reset_pin;               // Manual reset in force
        logic ext_ram;            // RAM region routed outside
        logic [7:0] rdata;        // Read answer, valid one cycle
    } msc_top_state_t;

    msc_top_state_t state_ff;
    msc_top_state_t nxt_state;
    logic dec_rom_en;  // Decoded straps, live from pins
    logic dec_ext_mode;
    logic dec_init_16;
    logic wr_sys;      // Write to system control
    logic rd_mon;      // Read of mode monitor
    logic rd_sys;      // Read of system control
    logic irq_bad;     // Write carries a prohibited interrupt mode

    // Strap decode of the pins; only used while reset is held
    msc_mode_decode u_decode (
        .mode_pins_i(mode_pin_i),
        .rom_en_o(dec_rom_en),
        .ext_mode_o(dec_ext_mode),
        .init_16_o(dec_init_16)
    );

    // NMI request on the edge chosen by the control register
    // The pin is taken as synchronous, so no extra stage sits here
    msc_edge_det u_nmi_edge (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .sig_i(nmi_pin_i),
        .rise_sel_i(state_ff.sys_ctrl[MSC_SC_NMI_EDGE]),
        .pulse_o(nmi_req_o)
    );

    // Register port decode
    // Addresses 2 and 3 decode to nothing and read back zero
    assign wr_sys = wr_i && (addr_i == MSC_OFS_SYS_CTRL);
    assign rd_mon = rd_i && (addr_i == MSC_OFS_MODE_MON);
    assign rd_sys = rd_i && (addr_i == MSC_OFS_SYS_CTRL);
    assign irq_bad = wdata_i[MSC_SC_IRQ_LO];

    // Next-state logic for all control state
    always_comb
    begin
        nxt_state = state_ff;
        // Manual reset request: pin is low-active and gated by enable
        // One cycle of lag keeps the output a plain flip-flop
        nxt_state.manual_reset_pin = state_ff.sys_ctrl[MSC_SC_MANUAL_RESET_PIN_EN] & ~manual_reset_pin_n_i;
        // Read data stand for one cycle only, zero otherwise
        nxt_state.rdata = 8'h00;
        if (rd_mon)
        begin
            // Fixed bits plus pin levels; status follows the pins
            nxt_state.rdata = MSC_MON_FIXED | {5'h00, mode_pin_i};
            nxt_state.mode_status = mode_pin_i;
        end
        else if (rd_sys)
        begin
            nxt_state.rdata = state_ff.sys_ctrl & MSC_SC_WR_MASK;
        end
        // Manual reset restores control, but keeps its own enable so
        // the pin stays effective, and keeps the caught status bits
        if (state_ff.manual_reset_pin)
        begin
            nxt_state.sys_ctrl = MSC_SC_RESET;
            nxt_state.sys_ctrl[MSC_SC_MANUAL_RESET_PIN_EN] = 1'b1;
            nxt_state.cfg_seen = 1'b0;
        end
        else if (wr_sys)
        begin
            // Monitor writes land nowhere; here only writable bits
            nxt_state.sys_ctrl = wdata_i & MSC_SC_WR_MASK;
            // A prohibited interrupt mode keeps the old selection
            if (irq_bad)
            begin
                nxt_state.sys_ctrl[MSC_SC_IRQ_HI:MSC_SC_IRQ_LO] =
                    state_ff.sys_ctrl[MSC_SC_IRQ_HI:MSC_SC_IRQ_LO];
            end
        end
        // A configuration write wins over the manual reset clear
        // so the bus controller never loses a width update
        if (area_cfg_wr_i)
            nxt_state.cfg_seen = 1'b1;
        // Width follows straps until the bus controller speaks
        // Single-chip keeps the width at eight: nothing lies outside
        if (!state_ff.ext_mode)
            nxt_state.bus_16 = 1'b0;
        else if (state_ff.cfg_seen)
            nxt_state.bus_16 = |area_16bit_i;
        else
            nxt_state.bus_16 = state_ff.init_16;
        // RAM disabled hands its region to external addresses
        nxt_state.ext_ram = ~state_ff.sys_ctrl[MSC_SC_RAM_EN];
    end

    // State register; straps load only while reset is held, so a
    // pin wiggle during operation cannot change the mode
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state_ff <= '0;
            state_ff.mode_status <= MSC_STATUS_RESET;
            state_ff.sys_ctrl <= MSC_SC_RESET;
            state_ff.rom_en <= dec_rom_en;
            state_ff.ext_mode <= dec_ext_mode;
            state_ff.init_16 <= dec_init_16;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from flip-flops
    assign rdata_o = state_ff.rdata;
    assign rom_enable_o = state_ff.rom_en;
    assign extended_mode_o = state_ff.ext_mode;
    assign init_bus_16bit_o = state_ff.init_16;
    assign bus_16bit_o = state_ff.bus_16;
    assign irq_ctrl_mode_o = state_ff.sys_ctrl[MSC_SC_IRQ_HI:MSC_SC_IRQ_LO];
    assign manual_reset_o = state_ff.manual_reset_pin;
    assign onchip_ram_enable_o = state_ff.sys_ctrl[MSC_SC_RAM_EN];
    assign ram_region_external_o = state_ff.ext_ram;

    // Checks on the logic above. They all run on the one clock and
    // sleep through power-on reset; the manual reset is not a reset
    // for them, since status and straps must ride through it
    default clocking chk_cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    chk_mon_fixed_bits: assert property (
        $past(rd_mon) |-> (rdata_o[7:3] == 5'h10))
        else $error("Monitor fixed bits wrong");

    chk_status_capture: assert property (
        rd_mon |=> (state_ff.mode_status == $past(mode_pin_i)
                    && rdata_o[2:0] == $past(mode_pin_i)))
        else $error("Monitor read did not catch the pins");

    chk_status_hold: assert property (
        (!rd_mon && !state_ff.manual_reset_pin) |=> $stable(state_ff.mode_status))
        else $error("Mode status changed without a read");

    chk_status_manual_reset_pin: assert property (
        state_ff.manual_reset_pin |=> $stable(state_ff.mode_status) || $past(rd_mon))
        else $error("Manual reset disturbed mode status");

    chk_rsvd_zero: assert property (
        $past(rd_sys) |-> (rdata_o[6] == 1'b0 && rdata_o[1] == 1'b0))
        else $error("Reserved control bits read non-zero");

    chk_irq_legal: assert property (
        irq_ctrl_mode_o == MSC_IRQ_MODE0 || irq_ctrl_mode_o == MSC_IRQ_MODE2)
        else $error("Prohibited interrupt mode held");

    chk_ram_after_reset: assert property (
        $fell(reset_i) |-> onchip_ram_enable_o && irq_ctrl_mode_o == MSC_IRQ_MODE0)
        else $error("Control register not at reset value");

    chk_manual_reset_pin_ignore: assert property (
        !state_ff.sys_ctrl[MSC_SC_MANUAL_RESET_PIN_EN] |=> !manual_reset_o)
        else $error("Manual reset taken while disabled");

    chk_strap_hold: assert property (
        ##1 ($stable(rom_enable_o) && $stable(extended_mode_o)
             && $stable(init_bus_16bit_o)))
        else $error("Strap outputs changed in operation");

    chk_single_chip: assert property (
        !extended_mode_o |-> ##1 (!bus_16bit_o && rom_enable_o))
        else $error("Single-chip mode shows external bus");

    chk_bus_width: assert property (
        (extended_mode_o && state_ff.cfg_seen) |=> (bus_16bit_o == $past(|area_16bit_i)))
        else $error("Bus width does not follow areas");

    chk_ram_route: assert property (
        !onchip_ram_enable_o |=> ram_region_external_o)
        else $error("RAM region not routed outside");

    chk_nmi_fall: assert property (
        (!state_ff.sys_ctrl[MSC_SC_NMI_EDGE] && nmi_pin_i) |=> !nmi_req_o)
        else $error("NMI request without falling edge");

    // A low pin cannot end a rising edge, so no request may follow
    chk_nmi_rise: assert property (
        (state_ff.sys_ctrl[MSC_SC_NMI_EDGE] && !nmi_pin_i) |=> !nmi_req_o)
        else $error("NMI request without rising edge");

    // Enabled pin held low must raise the manual reset a cycle later
    chk_manual_reset_pin_take: assert property (
        (state_ff.sys_ctrl[MSC_SC_MANUAL_RESET_PIN_EN] && !manual_reset_pin_n_i) |=> manual_reset_o)
        else $error("Enabled manual reset not taken");

    // Manual reset puts control back to its reset value, enable kept
    chk_manual_reset_pin_restore: assert property (
        manual_reset_o |=> (onchip_ram_enable_o && irq_ctrl_mode_o == MSC_IRQ_MODE0
                            && state_ff.sys_ctrl[MSC_SC_MANUAL_RESET_PIN_EN]
                            && state_ff.sys_ctrl[MSC_SC_NMI_EDGE] == MSC_EDGE_FALL))
        else $error("Manual reset did not restore control");

    // A legal write lands on the writable bits only
    chk_sys_write: assert property (
        (wr_sys && !wdata_i[MSC_SC_IRQ_LO] && !state_ff.manual_reset_pin)
        |=> (state_ff.sys_ctrl == ($past(wdata_i) & MSC_SC_WR_MASK)))
        else $error("Control write did not land");

    // A prohibited interrupt mode leaves the selection alone
    chk_irq_refused: assert property (
        (wr_sys && wdata_i[MSC_SC_IRQ_LO] && !state_ff.manual_reset_pin) |=> $stable(irq_ctrl_mode_o))
        else $error("Prohibited interrupt mode accepted");

    // Monitor writes must not touch the caught status bits
    chk_mon_write: assert property (
        (wr_i && !rd_i && addr_i == MSC_OFS_MODE_MON) |=> $stable(state_ff.mode_status))
        else $error("Monitor write changed status");

    // Legal straps decode into the table values at reset release
    chk_strap_decode: assert property (
        ($fell(reset_i) && mode_pin_i[2])
        |-> (rom_enable_o == mode_pin_i[1]
             && extended_mode_o == (mode_pin_i != MSC_MODE7)
             && init_bus_16bit_o == (mode_pin_i == MSC_MODE4)))
        else $error("Strap decode wrong");

    // First width after release comes from the strap alone
    chk_bus_start: assert property (
        $fell(reset_i) |=> (bus_16bit_o == (extended_mode_o && init_bus_16bit_o)))
        else $error("Initial bus width wrong");

    // RAM enabled keeps its region on chip
    chk_ram_onchip: assert property (
        onchip_ram_enable_o |=> !ram_region_external_o)
        else $error("RAM region routed outside while enabled");

    // Control reads give back the stored value, reserved bits zero
    chk_sys_readback: assert property (
        rd_sys |=> (rdata_o == $past(state_ff.sys_ctrl)))
        else $error("Control read does not match storage");

    cov_mon_read: cover property (rd_mon ##1 rdata_o[7]);
    cov_manual_reset_pin: cover property (manual_reset_o ##1 !manual_reset_o);
    cov_nmi: cover property (nmi_req_o);
    cov_bus_widen: cover property (!bus_16bit_o ##1 bus_16bit_o);
    cov_irq_mode2: cover property (irq_ctrl_mode_o == MSC_IRQ_MODE2);
endmodule : msc_top

// ---- testbench/msc_board_model.sv ----
// Board side model: the mode strap pins seen by the device.
// Assumes the bench sets strap_i before it raises reset_i.
`timescale 1ns/1ns
module msc_board_model
    import msc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [2:0] strap_i,
    output logic [2:0] mode_pin_o
);
    // Pins power up on the single-chip strap
    initial mode_pin_o = MSC_MODE7;
    // Straps move only while the device is held in reset, never in operation
    always @(posedge ref_clk_i)
    begin
        if (reset_i)
            mode_pin_o <= strap_i;
    end
endmodule : msc_board_model

// ---- testbench/test_mode_select_and_system_control.sv ----
// Self-checking bench for the mode select and system control block.
// Assumes msc_top and the board model; register reads checked from a queue.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_mode_select_and_system_control
    import msc_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic reset_i, manual_reset_pin_n, nmi, cfg_wr, wr, rd;
    logic [2:0] strap, mode_pin;
    logic [7:0] area, wdata, rdata, sc, exp_v;
    logic [1:0] addr, irq_mode;
    logic rom_en, ext, init16, bus16, nmi_req, manual_reset_pin, ram_en, ram_ext;
    logic rd_pend_ff = 1'b0; // A read answer is due at this edge
    logic [7:0] exp_q[$]; // Expected read data, oldest first
    int n_mismatch = 0;
    int cmp_count = 0;

    // 100 MHz clock
    always #5 ref_clk_i = ~ref_clk_i;

    msc_board_model i_board (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .strap_i(strap),
        .mode_pin_o(mode_pin));

    msc_top i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .mode_pin_i(mode_pin),
        .manual_reset_pin_n_i(manual_reset_pin_n), .nmi_pin_i(nmi), .area_16bit_i(area),
        .area_cfg_wr_i(cfg_wr), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .rom_enable_o(rom_en), .extended_mode_o(ext),
        .init_bus_16bit_o(init16), .bus_16bit_o(bus16), .irq_ctrl_mode_o(irq_mode),
        .nmi_req_o(nmi_req), .manual_reset_o(manual_reset_pin), .onchip_ram_enable_o(ram_en),
        .ram_region_external_o(ram_ext));

    // Verdict; also reached from the watchdog
    task automatic tally_and_finish();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // One bus cycle; strobes stay up until the next call, so transfers may abut
    task automatic bus(input logic w, input logic r, input logic [1:0] a,
        input logic [7:0] d, input logic [7:0] e);
        @(posedge ref_clk_i);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        if (r)
            exp_q.push_back(e);
    endtask : bus

    // Drop both strobes
    task automatic idle();
        bus(1'b0, 1'b0, 2'h0, 8'h00, 8'h00);
    endtask : idle

    // System control write, with the expected register image kept alongside
    task automatic sc_wr(input logic [7:0] d);
        logic [7:0] n;
        n = d & MSC_SC_WR_MASK;
        if (d[MSC_SC_IRQ_LO])
            n[5:4] = sc[5:4];
        sc = n;
        bus(1'b1, 1'b0, MSC_OFS_SYS_CTRL, d, 8'h00);
    endtask : sc_wr

    // Power-on reset held ten cycles; straps follow strap
    task automatic do_reset();
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        sc = MSC_SC_RESET;
        @(posedge ref_clk_i);
        #1;
    endtask : do_reset

    // Area width update, then the resulting bus width
    task automatic cfg(input logic [7:0] v, input logic e);
        @(posedge ref_clk_i);
        area <= v;
        cfg_wr <= 1'b1;
        @(posedge ref_clk_i);
        cfg_wr <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        `CHK("bus width", e & (|v), bus16)
    endtask : cfg

    // Count request pulses over four cycles after an NMI pin change
    task automatic nmi_try(input logic rise);
        int cnt;
        sc_wr({4'h0, rise, 3'h1});
        idle();
        nmi <= rise;
        repeat (3) @(posedge ref_clk_i);
        nmi <= ~rise;
        cnt = 0;
        repeat (4)
        begin
            @(posedge ref_clk_i);
            #1;
            if (nmi_req === 1'b1)
                cnt++;
        end
        `CHK("nmi wrong edge", 0, cnt)
        nmi <= rise;
        cnt = 0;
        repeat (4)
        begin
            @(posedge ref_clk_i);
            #1;
            if (nmi_req === 1'b1)
                cnt++;
        end
        `CHK("nmi chosen edge", 1, cnt)
    endtask : nmi_try

    // Read checker: takes the oldest note whenever an answer is due
    always @(posedge ref_clk_i)
    begin
        if (rd_pend_ff)
        begin
            exp_v = exp_q.pop_front();
            `CHK("read data", exp_v, rdata)
        end
        else if (!reset_i)
            `CHK("idle read data", 8'h00, rdata)
        rd_pend_ff <= rd;
    end

    // Watchdog well beyond the expected few hundred cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk_i);
        n_mismatch++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        reset_i = 1'b1;
        strap = MSC_MODE4;
        manual_reset_pin_n = 1'b1;
        nmi = 1'b0;
        area = 8'h00;
        cfg_wr = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        sc = MSC_SC_RESET;
        void'($urandom(99262));
        // Every mode, each from a fresh power-on reset
        for (int m = 4; m < 8; m++)
        begin
            strap <= m[2:0];
            do_reset();
            `CHK("rom enable", m[1], rom_en)
            `CHK("extended mode", (m != 7), ext)
            `CHK("initial 16 bit", (m == 4), init16)
            `CHK("bus width reset", (m == 4), bus16)
            `CHK("ram enable reset", 1'b1, ram_en)
            `CHK("irq mode reset", MSC_IRQ_MODE0, irq_mode)
            bus(1'b0, 1'b1, MSC_OFS_MODE_MON, 8'h00, MSC_MON_FIXED | m[2:0]);
            bus(1'b1, 1'b0, MSC_OFS_MODE_MON, 8'hff, 8'h00);
            bus(1'b0, 1'b1, MSC_OFS_MODE_MON, 8'h00, MSC_MON_FIXED | m[2:0]);
            bus(1'b0, 1'b1, MSC_OFS_SYS_CTRL, 8'h00, MSC_SC_RESET);
            bus(1'b0, 1'b1, {1'b1, m[0]}, 8'h00, 8'h00);
            idle();
            cfg(8'($urandom_range(1, 255)), (m != 7));
            cfg(8'h00, 1'b0);
            repeat (3)
            begin
                sc_wr(8'($urandom) & 8'h7f);
                idle();
                #1;
                `CHK("irq mode", sc[5:4], irq_mode)
                `CHK("ram enable", sc[MSC_SC_RAM_EN], ram_en)
                @(posedge ref_clk_i);
                #1;
                `CHK("ram external", ~sc[MSC_SC_RAM_EN], ram_ext)
                bus(1'b0, 1'b1, MSC_OFS_SYS_CTRL, 8'h00, sc);
                idle();
            end
        end
        nmi_try(MSC_EDGE_FALL);
        nmi_try(~MSC_EDGE_FALL);
        // Manual reset pin ignored while disabled, then taken once enabled
        sc_wr(8'h01);
        idle();
        manual_reset_pin_n <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        `CHK("manual reset off", 1'b0, manual_reset_pin)
        manual_reset_pin_n <= 1'b1;
        sc_wr(8'h0d);
        idle();
        manual_reset_pin_n <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        `CHK("manual reset on", 1'b1, manual_reset_pin)
        manual_reset_pin_n <= 1'b1;
        sc = 8'h05;
        repeat (3) @(posedge ref_clk_i);
        bus(1'b0, 1'b1, MSC_OFS_SYS_CTRL, 8'h00, sc);
        bus(1'b0, 1'b1, MSC_OFS_MODE_MON, 8'h00, MSC_MON_FIXED | MSC_MODE7);
        idle();
        repeat (3) @(posedge ref_clk_i);
        tally_and_finish();
    end
endmodule : test_mode_select_and_system_control
